// >>> rtl/tm2_defines.svh
/*
 * register offsets, field positions, reset values and response codes of
 * the timer-2 register block.
 * assumes: included by bare name; definitions only.
 */
`ifndef TM2_DEFINES_SVH
`define TM2_DEFINES_SVH

// byte offsets on the register bus
`define TM2_OFS_CTLA        8'h00
`define TM2_OFS_CTLB        8'h04
`define TM2_OFS_VALUE       8'h08
`define TM2_OFS_VALUE_HI    8'h0c
`define TM2_OFS_RELOAD      8'h10
`define TM2_OFS_RELOAD_HI   8'h14
`define TM2_OFS_CC          8'h18
`define TM2_OFS_CC_HI       8'h1c

// control-b field positions
`define TM2_B_LOW_IRQ_EN    7
`define TM2_B_ALT_OE        6
`define TM2_B_ALT_POL       5
`define TM2_B_RSVD          4
`define TM2_B_MAIN_OVF      3
`define TM2_B_LOW_OVF       2
`define TM2_B_CC_FLAG       1
`define TM2_B_LOW_CMP       0

// control-a field positions
`define TM2_A_MAIN_IRQ_EN   7
`define TM2_A_CAP_MODE      6
`define TM2_A_LOW_RUN       4
`define TM2_A_RUN           3
`define TM2_A_SPLIT         2

// reset values
`define TM2_RST_BYTE        8'h00
`define TM2_RST_WORD        16'h0000

// bus response codes
`define TM2_RESP_OKAY       2'b00
`define TM2_RESP_SLVERR     2'b10

`endif

// >>> rtl/tm2_pkg.sv
/*
 * types of the timer-2 register block: bus carriers and control fields.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package tm2_pkg;

   // master-driven half of the register bus
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } tm2_axi_req_s;

   // slave-driven half of the register bus
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tm2_axi_rsp_s;

   // first control register, laid out msb first
   typedef struct packed {
      logic       main_irq_enable;
      logic       capture_mode;
      logic       rsvd5;
      logic       low_run;
      logic       run;
      logic       split_mode_select;
      logic [1:0] rsvd;
   } tm2_ctla_s;

endpackage : tm2_pkg

// >>> rtl/tm2_timer.sv
/*
 * timer-2 register block: control-b, count, reload and capture/compare
 * registers with their high-byte aliases, a small counting engine, the
 * alternate output pin and an AXI4-Lite slave.
 * assumes: one clock, synchronous active-high reset, capture pin async.
 */
`timescale 1ns/100ps
`include "tm2_defines.svh"

module tm2_timer
   import tm2_pkg::*;
#(
   parameter bit HAS_ALT_PIN = 1'b1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // register bus
   input  wire tm2_axi_req_s axi_req,
   output      tm2_axi_rsp_s axi_rsp,
   // capture input pin
   input  wire logic         capture_pin,
   // alternate output pin and interrupt
   output      logic         alternate_output_pin,
   output      logic         alternate_output_pin_oe_n,
   output      logic         irq
);

   ////////////////////////////////////////////////////////////////////////
   // state
   tm2_axi_rsp_s rsp_r;
   logic         aw_held_r;
   logic         w_held_r;
   logic [7:0]   waddr_r;
   logic [31:0]  wdata_r;
   logic [3:0]   wstrb_r;
   tm2_ctla_s    ctla_r;
   logic         low_irq_enable_r;
   logic         alt_pin_output_enable_r;
   logic         alt_pin_polarity_r;
   logic         alt_oe_prev_r;
   logic         alt_oe_n_r;
   logic [3:0]   flags_r;
   logic [15:0]  count_r;
   logic [15:0]  reload_r;
   logic [15:0]  cc_r;
   logic [2:0]   cap_sync_r;
   logic         pin_r;
   logic         irq_r;

   assign axi_rsp                   = rsp_r;
   assign alternate_output_pin      = pin_r;
   assign alternate_output_pin_oe_n = alt_oe_n_r;
   assign irq                       = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // write decode
   logic wr_fire;
   logic wr_ctla;
   logic wr_ctlb;
   logic wr_val;
   logic wr_val_hi;
   logic wr_rel;
   logic wr_rel_hi;
   logic wr_cc;
   logic wr_cc_hi;
   logic wr_mapped;

   assign wr_fire   = aw_held_r && w_held_r && !rsp_r.bvalid;
   assign wr_ctla   = wr_fire && waddr_r == `TM2_OFS_CTLA      && wstrb_r[0];
   assign wr_ctlb   = wr_fire && waddr_r == `TM2_OFS_CTLB      && wstrb_r[0];
   assign wr_val    = wr_fire && waddr_r == `TM2_OFS_VALUE;
   assign wr_val_hi = wr_fire && waddr_r == `TM2_OFS_VALUE_HI  && wstrb_r[0];
   assign wr_rel    = wr_fire && waddr_r == `TM2_OFS_RELOAD;
   assign wr_rel_hi = wr_fire && waddr_r == `TM2_OFS_RELOAD_HI && wstrb_r[0];
   assign wr_cc     = wr_fire && waddr_r == `TM2_OFS_CC;
   assign wr_cc_hi  = wr_fire && waddr_r == `TM2_OFS_CC_HI     && wstrb_r[0];
   assign wr_mapped = waddr_r[1:0] == 2'b00 && waddr_r <= `TM2_OFS_CC_HI;

   ////////////////////////////////////////////////////////////////////////
   // events of the counting engine
   logic split;
   logic full_ovf;
   logic hi_ovf;
   logic lo_ovf;
   logic main_ovf;
   logic cmp_full;
   logic cmp_hi;
   logic cmp_lo;
   logic cap_evt;
   logic cc_evt;
   logic wave_ovf;
   logic wave_cmp;

   assign split    = ctla_r.split_mode_select;
   assign full_ovf = ctla_r.run && !split && count_r == 16'hffff;
   assign hi_ovf   = ctla_r.run && split && count_r[15:8] == 8'hff;
   assign lo_ovf   = ctla_r.low_run && split && count_r[7:0] == 8'hff;
   assign main_ovf = full_ovf || hi_ovf;
   assign cmp_full = ctla_r.run && !split && count_r == cc_r;
   assign cmp_hi   = ctla_r.run && split
                     && count_r[15:8] == cc_r[15:8];
   // low half is always in compare mode
   assign cmp_lo   = ctla_r.low_run && split
                     && count_r[7:0] == cc_r[7:0];
   // rising edge seen on the second and third stages only
   assign cap_evt  = ctla_r.capture_mode
                     && cap_sync_r[1] && !cap_sync_r[2];
   assign cc_evt   = cap_evt
                     || (!ctla_r.capture_mode && (cmp_full || cmp_hi));
   assign wave_ovf = split ? lo_ovf : full_ovf;
   assign wave_cmp = split ? cmp_lo : cmp_full;

   ////////////////////////////////////////////////////////////////////////
   // capture pin synchroniser
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cap_sync_r <= 3'h0;
      end else begin
         cap_sync_r <= {cap_sync_r[1:0], capture_pin};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data assembly; split mode hides the upper bytes at the base offsets, the high aliases still show them
   logic [31:0] rd_word;
   logic        rd_ok;
   logic [7:0]  ctlb_view;

   assign ctlb_view = {low_irq_enable_r, alt_pin_output_enable_r,
                       alt_pin_polarity_r, 1'b0, flags_r};

   always_comb begin
      rd_ok   = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (axi_req.araddr[7:0])
         `TM2_OFS_CTLA:      rd_word[7:0] = ctla_r;
         `TM2_OFS_CTLB:      rd_word[7:0] = ctlb_view;
         `TM2_OFS_VALUE:     rd_word[15:0] = {split ? 8'h00 : count_r[15:8],
                                              count_r[7:0]};
         `TM2_OFS_VALUE_HI:  rd_word[7:0] = count_r[15:8];
         `TM2_OFS_RELOAD:    rd_word[15:0] = {split ? 8'h00 : reload_r[15:8],
                                              reload_r[7:0]};
         `TM2_OFS_RELOAD_HI: rd_word[7:0] = reload_r[15:8];
         `TM2_OFS_CC:        rd_word[15:0] = {split ? 8'h00 : cc_r[15:8],
                                              cc_r[7:0]};
         `TM2_OFS_CC_HI:     rd_word[7:0] = cc_r[15:8];
         default:            rd_ok = 1'b0;
      endcase
   end

   // bus channels in one process: all answers share one response struct;
   // write address and data taken in either order, one read at a time
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         waddr_r       <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         rsp_r         <= '0;
      end else begin
         rsp_r.awready <= !aw_held_r && !rsp_r.awready && !rsp_r.bvalid;
         rsp_r.wready  <= !w_held_r && !rsp_r.wready && !rsp_r.bvalid;
         if (axi_req.awvalid && rsp_r.awready) begin
            aw_held_r <= 1'b1;
            waddr_r   <= axi_req.awaddr[7:0];
         end
         if (axi_req.wvalid && rsp_r.wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= axi_req.wdata;
            wstrb_r  <= axi_req.wstrb;
         end
         if (wr_fire) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            rsp_r.bvalid <= 1'b1;
            rsp_r.bresp  <= wr_mapped ? `TM2_RESP_OKAY : `TM2_RESP_SLVERR;
         end else if (rsp_r.bvalid && axi_req.bready) begin
            rsp_r.bvalid <= 1'b0;
         end
         rsp_r.arready <= !rsp_r.arready && !rsp_r.rvalid;
         if (axi_req.arvalid && rsp_r.arready) begin
            rsp_r.rvalid <= 1'b1;
            rsp_r.rdata  <= rd_word;
            rsp_r.rresp  <= rd_ok ? `TM2_RESP_OKAY : `TM2_RESP_SLVERR;
         end else if (rsp_r.rvalid && axi_req.rready) begin
            rsp_r.rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctla_r                  <= tm2_ctla_s'(`TM2_RST_BYTE);
         low_irq_enable_r        <= 1'b0;
         alt_pin_output_enable_r <= 1'b0;
         alt_pin_polarity_r      <= 1'b0;
      end else begin
         if (wr_ctla) begin
            ctla_r      <= tm2_ctla_s'(wdata_r[7:0]);
            ctla_r.rsvd5 <= 1'b0;
            ctla_r.rsvd  <= 2'b00;
         end
         if (wr_ctlb) begin
            low_irq_enable_r        <= wdata_r[`TM2_B_LOW_IRQ_EN];
            // not built on single-pin variants
            alt_pin_output_enable_r <= HAS_ALT_PIN
                                       && wdata_r[`TM2_B_ALT_OE];
            alt_pin_polarity_r      <= wdata_r[`TM2_B_ALT_POL];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event flags: hardware set beats a software clear in the same cycle
   logic [3:0] flag_set;
   assign flag_set = {main_ovf, lo_ovf, cc_evt, cmp_lo};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               flags_r[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               flags_r[gi] <= 1'b1;
            end else if (wr_ctlb) begin
               flags_r[gi] <= flags_r[gi] & wdata_r[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // interrupt request: main pair gated by control-a, low pair by control-b
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (ctla_r.main_irq_enable
                   && (flags_r[`TM2_B_MAIN_OVF]
                       || flags_r[`TM2_B_CC_FLAG]))
                  || (low_irq_enable_r
                      && (flags_r[`TM2_B_LOW_OVF]
                          || flags_r[`TM2_B_LOW_CMP]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // count: a software load takes priority over counting that cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_r <= `TM2_RST_WORD;
      end else begin
         if (!split) begin
            if (full_ovf) begin
               count_r <= reload_r;
            end else if (ctla_r.run) begin
               count_r <= count_r + 16'h0001;
            end
         end else begin
            if (hi_ovf) begin
               count_r[15:8] <= reload_r[15:8];
            end else if (ctla_r.run) begin
               count_r[15:8] <= count_r[15:8] + 8'h01;
            end
            if (lo_ovf) begin
               count_r[7:0] <= reload_r[7:0];
            end else if (ctla_r.low_run) begin
               count_r[7:0] <= count_r[7:0] + 8'h01;
            end
         end
         if (wr_val && wstrb_r[0]) begin
            count_r[7:0] <= wdata_r[7:0];
         end
         if (wr_val && wstrb_r[1] && !split) begin
            count_r[15:8] <= wdata_r[15:8];
         end
         if (wr_val_hi) begin
            count_r[15:8] <= wdata_r[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reload value
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reload_r <= `TM2_RST_WORD;
      end else begin
         if (wr_rel && wstrb_r[0]) begin
            reload_r[7:0] <= wdata_r[7:0];
         end
         if (wr_rel && wstrb_r[1] && !split) begin
            reload_r[15:8] <= wdata_r[15:8];
         end
         if (wr_rel_hi) begin
            reload_r[15:8] <= wdata_r[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture/compare: a capture beats a software write in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cc_r <= `TM2_RST_WORD;
      end else if (cap_evt) begin
         if (split) begin
            cc_r[15:8] <= count_r[15:8];
         end else begin
            cc_r <= count_r;
         end
      end else begin
         if (wr_cc && wstrb_r[0]) begin
            cc_r[7:0] <= wdata_r[7:0];
         end
         if (wr_cc && wstrb_r[1] && !split) begin
            cc_r[15:8] <= wdata_r[15:8];
         end
         if (wr_cc_hi) begin
            cc_r[15:8] <= wdata_r[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alternate pin: starts at polarity when enabled, inverts on match
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         alt_oe_prev_r <= 1'b0;
         alt_oe_n_r    <= 1'b1;
         pin_r         <= 1'b0;
      end else begin
         alt_oe_prev_r <= alt_pin_output_enable_r;
         // own flop so the pin enable leaves the block glitch free
         alt_oe_n_r    <= !alt_pin_output_enable_r;
         if (alt_pin_output_enable_r && !alt_oe_prev_r) begin
            pin_r <= alt_pin_polarity_r;
         end else if (alt_oe_prev_r && wave_ovf) begin
            pin_r <= alt_pin_polarity_r;
         end else if (alt_oe_prev_r && wave_cmp) begin
            pin_r <= ~alt_pin_polarity_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_main_ovf;
      @(posedge clk_sys) disable iff (reset)
      main_ovf |=> flags_r[`TM2_B_MAIN_OVF];
   endproperty
   a_main_ovf: assert property (p_main_ovf)
      else $error("main overflow flag not set");

   property p_low_ovf;
      @(posedge clk_sys) disable iff (reset)
      lo_ovf |=> flags_r[`TM2_B_LOW_OVF] && count_r[7:0] == $past(reload_r[7:0])
                 || $past(wr_val);
   endproperty
   a_low_ovf: assert property (p_low_ovf)
      else $error("low overflow flag or reload wrong");

   property p_cc_flag;
      @(posedge clk_sys) disable iff (reset)
      (cap_evt || (!ctla_r.capture_mode && cmp_full))
         |=> flags_r[`TM2_B_CC_FLAG];
   endproperty
   a_cc_flag: assert property (p_cc_flag)
      else $error("capture/compare flag not set");

   property p_low_cmp_split;
      @(posedge clk_sys) disable iff (reset)
      $rose(flags_r[`TM2_B_LOW_CMP]) |-> $past(split);
   endproperty
   a_low_cmp_split: assert property (p_low_cmp_split)
      else $error("low compare flag set outside split mode");

   property p_cap_low_kept;
      @(posedge clk_sys) disable iff (reset)
      cap_evt && split |=> cc_r[7:0] == $past(cc_r[7:0])
                           && cc_r[15:8] == $past(count_r[15:8]);
   endproperty
   a_cap_low_kept: assert property (p_cap_low_kept)
      else $error("split capture touched the low byte");

   property p_split_read;
      @(posedge clk_sys) disable iff (reset)
      axi_req.arvalid && rsp_r.arready && split
         && axi_req.araddr[7:0] == `TM2_OFS_VALUE
         |=> rsp_r.rvalid && rsp_r.rdata[15:8] == 8'h00;
   endproperty
   a_split_read: assert property (p_split_read)
      else $error("split value read shows upper byte");

   property p_bit4;
      @(posedge clk_sys) disable iff (reset)
      axi_req.arvalid && rsp_r.arready
         && axi_req.araddr[7:0] == `TM2_OFS_CTLB
         |=> !rsp_r.rdata[`TM2_B_RSVD];
   endproperty
   a_bit4: assert property (p_bit4)
      else $error("control-b bit 4 read as one");

   property p_irq_low;
      @(posedge clk_sys) disable iff (reset)
      low_irq_enable_r && flags_r[`TM2_B_LOW_OVF] |=> irq_r;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("low interrupt not raised");

   property p_pin_start;
      @(posedge clk_sys) disable iff (reset)
      $rose(alt_pin_output_enable_r)
         |=> pin_r == $past(alt_pin_polarity_r) && !alternate_output_pin_oe_n;
   endproperty
   a_pin_start: assert property (p_pin_start)
      else $error("pin did not start at polarity");

   property p_no_alt;
      @(posedge clk_sys) disable iff (reset)
      !HAS_ALT_PIN |-> !alt_pin_output_enable_r;
   endproperty
   a_no_alt: assert property (p_no_alt)
      else $error("alternate enable set on single-pin build");

   c_full_ovf: cover property (@(posedge clk_sys) disable iff (reset)
                               full_ovf);
   c_split_cap: cover property (@(posedge clk_sys) disable iff (reset)
                                cap_evt && split);
   c_irq: cover property (@(posedge clk_sys) disable iff (reset)
                          $rose(irq_r));

endmodule : tm2_timer

// >>> sim/testbench.sv
/* self-checking bench for the timer-2 register block over AXI4-Lite.
   assumes: tm2_pkg and tm2_timer compiled first; offsets from defines. */
`timescale 1ns/100ps
`include "tm2_defines.svh"

module testbench;
   import tm2_pkg::*;

   // expected read answer, queued by the driver
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } tm2_note_s;

   logic         clk_sys;
   logic         reset;
   logic         capture_pin;
   logic         alt_pin;
   logic         alt_oe_n;
   logic         irq;
   tm2_axi_req_s axi_req;
   tm2_axi_rsp_s axi_rsp;
   tm2_note_s    notes[$];
   logic [1:0]   wr_notes[$];
   int           err_count = 0;
   int           total_checks = 0;
   int           cycles = 0;
   logic [15:0]  v;
   logic [15:0]  w;
   logic [7:0]   h;
   logic [7:0]   ofs[3] = '{8'h08, 8'h10, 8'h18};

   tm2_timer i_tm2_timer (
      .clk_sys                  (clk_sys),
      .reset                    (reset),
      .axi_req                  (axi_req),
      .axi_rsp                  (axi_rsp),
      .capture_pin              (capture_pin),
      .alternate_output_pin     (alt_pin),
      .alternate_output_pin_oe_n(alt_oe_n),
      .irq                      (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and verdict
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // a few hundred cycles are expected; the ceiling leaves wide margin
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input logic [31:0] m);
      total_checks++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   // capture pin pulse, long enough to cross the three-stage synchroniser
   task automatic pulse();
      capture_pin <= 1'b1;
      tick(4);
      capture_pin <= 1'b0;
      tick(4);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   // bus master: valid and payload held until each channel is taken
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] r = `TM2_RESP_OKAY);
      logic aw;
      logic wd;
      wr_notes.push_back(r);
      @(posedge clk_sys);
      aw = 1'b1;
      wd = 1'b1;
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr  <= {24'h0, a};
      axi_req.wvalid  <= 1'b1;
      axi_req.wdata   <= {16'h0, d};
      axi_req.wstrb   <= 4'hf;
      axi_req.bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (aw && axi_rsp.awready === 1'b1) begin
            aw = 1'b0;
            axi_req.awvalid <= 1'b0;
         end
         if (wd && axi_rsp.wready === 1'b1) begin
            wd = 1'b0;
            axi_req.wvalid <= 1'b0;
         end
      end while (axi_rsp.bvalid !== 1'b1);
      axi_req.bready <= 1'b0;
   endtask : wr

   // read: note the expectation, the watcher below compares it
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffffffff,
                     input logic [1:0] r = `TM2_RESP_OKAY);
      logic ar;
      notes.push_back('{d, m, r});
      @(posedge clk_sys);
      ar = 1'b1;
      axi_req.arvalid <= 1'b1;
      axi_req.araddr  <= {24'h0, a};
      axi_req.rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (ar && axi_rsp.arready === 1'b1) begin
            ar = 1'b0;
            axi_req.arvalid <= 1'b0;
         end
      end while (axi_rsp.rvalid !== 1'b1);
      axi_req.rready <= 1'b0;
   endtask : rd

   // watcher: each accepted read answer meets the oldest note
   always @(posedge clk_sys) begin
      if (axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1) begin
         if (notes.size() == 0) begin
            err_count++;
            $display("BAD %0t read answer with nothing expected", $time);
         end else begin
            chk(axi_rsp.rdata, notes[0].d, notes[0].m);
            chk({30'h0, axi_rsp.rresp}, {30'h0, notes[0].r}, 32'h3);
            void'(notes.pop_front());
         end
      end
      if (axi_rsp.bvalid === 1'b1 && axi_req.bready === 1'b1) begin
         if (wr_notes.size() == 0) begin
            err_count++;
            $display("BAD %0t write answer with nothing expected", $time);
         end else begin
            chk({30'h0, axi_rsp.bresp}, {30'h0, wr_notes[0]}, 32'h3);
            void'(wr_notes.pop_front());
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      axi_req = '0;
      capture_pin = 1'b0;
      reset = 1'b1;
      v = 16'($urandom(50));
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
      // each wide register, then its split view and high alias
      foreach (ofs[k]) begin
         v = 16'($urandom);
         w = 16'($urandom);
         h = 8'($urandom);
         wr(`TM2_OFS_CTLA, 16'h0000);
         wr(ofs[k], v);
         rd(ofs[k], {16'h0, v});
         wr(`TM2_OFS_CTLA, 16'h0004);
         rd(ofs[k], {24'h0, v[7:0]});
         rd(ofs[k] + 8'h04, {24'h0, v[15:8]});
         wr(ofs[k], w);
         rd(ofs[k], {24'h0, w[7:0]});
         rd(ofs[k] + 8'h04, {24'h0, v[15:8]});
         wr(ofs[k] + 8'h04, {8'h0, h});
         rd(ofs[k] + 8'h04, {24'h0, h});
      end
      // split: low timer runs fe, ff (match), 00 (overflow)
      wr(`TM2_OFS_RELOAD, 16'h0000);
      wr(`TM2_OFS_CC, 16'h00ff);
      wr(`TM2_OFS_VALUE, 16'h00fe);
      wr(`TM2_OFS_CTLA, 16'h0014);
      wr(`TM2_OFS_CTLA, 16'h0004);
      rd(`TM2_OFS_CTLB, 32'h05, 32'h0f);
      wr(`TM2_OFS_CTLB, 16'h0085);
      tick(3);
      chk({31'h0, irq}, 32'h1, 32'h1);
      wr(`TM2_OFS_CTLB, 16'h0090);
      rd(`TM2_OFS_CTLB, 32'h80);
      tick(3);
      chk({31'h0, irq}, 32'h0, 32'h1);
      // 16-bit: overflow past ffff with a match at ffff
      wr(`TM2_OFS_CTLA, 16'h0000);
      wr(`TM2_OFS_CTLB, 16'h0000);
      wr(`TM2_OFS_CC, 16'hffff);
      wr(`TM2_OFS_VALUE, 16'hfffe);
      wr(`TM2_OFS_CTLA, 16'h0008);
      wr(`TM2_OFS_CTLA, 16'h0000);
      rd(`TM2_OFS_CTLB, 32'h0a, 32'h0b);
      tick(3);
      chk({31'h0, irq}, 32'h0, 32'h1);
      wr(`TM2_OFS_CTLA, 16'h0080);
      tick(3);
      chk({31'h0, irq}, 32'h1, 32'h1);
      // alternate pin: start level only applied on enable rising
      wr(`TM2_OFS_CTLB, 16'h0020);
      rd(`TM2_OFS_CTLB, 32'h20);
      wr(`TM2_OFS_CTLB, 16'h0060);
      tick(2);
      chk({30'h0, alt_pin, alt_oe_n}, 32'h2, 32'h3);
      wr(`TM2_OFS_CTLB, 16'h0040);
      tick(2);
      chk({30'h0, alt_pin, alt_oe_n}, 32'h2, 32'h3);
      // external capture on a held count: 16-bit, then split
      wr(`TM2_OFS_CTLB, 16'h0000);
      wr(`TM2_OFS_VALUE, v);
      wr(`TM2_OFS_CTLA, 16'h0040);
      pulse();
      rd(`TM2_OFS_CC, {16'h0, v});
      rd(`TM2_OFS_CTLB, 32'h02);
      wr(`TM2_OFS_CTLA, 16'h0044);
      wr(`TM2_OFS_CC_HI, {8'h0, h});
      wr(`TM2_OFS_CC, w);
      pulse();
      rd(`TM2_OFS_CC_HI, {24'h0, v[15:8]});
      rd(`TM2_OFS_CC, {24'h0, w[7:0]});
      wr(`TM2_OFS_CTLA, 16'h0000);
      // unmapped place is refused and reads zero
      wr(8'h40, 16'h1234, `TM2_RESP_SLVERR);
      rd(8'h40, 32'h0, 32'hffffffff, `TM2_RESP_SLVERR);
      tick(3);
      if (notes.size() + wr_notes.size() != 0) begin
         err_count++;
         $display("BAD %0t bus answers missing", $time);
      end
      complete_run();
   end

endmodule : testbench
